// [hw/sss_pkg.sv]
// ============================================================
// Shared constants of the spin sun sensor readout
package sss_pkg;

   // ============================================================
   // Readout register layout
   localparam int unsigned SSS_REG_W      = 16;  // Recirculating register width
   localparam int unsigned SSS_ANG_W      = 9;   // Gray angle incl. sign
   localparam int unsigned SSS_MAG_W      = 8;   // Non-sign angle bits
   localparam int unsigned SSS_WORD_BITS  = 8;   // Bits per serial word
   localparam int unsigned SSS_ANG_MSB    = 15;  // Sign bit, shifted out first
   localparam int unsigned SSS_ANG_LSB    = 7;
   localparam int unsigned SSS_STAT_POS   = 0;   // Sixteenth bit, shifted out last
   localparam int unsigned SSS_ANG_STEPS  = 360; // Half-degree steps over the range

   // ============================================================
   // Reset values and counts
   localparam logic [15:0] SSS_SNAP_RST   = 16'h0000;
   localparam logic [3:0]  SSS_CNT_RST    = 4'h0;
   localparam logic [3:0]  SSS_CNT_FIRST  = 4'h1;
   localparam logic [3:0]  SSS_CNT_LAST   = 4'hf;  // Sixteenth shift pulse
   localparam int unsigned SSS_BUF_DEPTH  = 2;

endpackage

// [hw/sss_buf2.sv]
`timescale 1ns/1ps
// ============================================================
// Small FIFO between sun pulse capture and the readout snapshot
module sss_buf2 #(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 2
) (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst,
   // Filling side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Draining side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int unsigned CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0]               wr;
      logic [PW-1:0]               rd;
      logic [CW-1:0]               cnt;
   } sss_buf_t;

   sss_buf_t b_reg;
   sss_buf_t b_next;
   logic     push;
   logic     pop;

   // Pointer advance with wrap at the last entry
   function automatic logic [PW-1:0] sss_wrap(input logic [PW-1:0] p);
      if (p == PW'(DEPTH - 1)) begin
         return '0;
      end
      return p + PW'(1);
   endfunction

   // Flags come from the count, so full and empty are exact
   assign in_ready  = (b_reg.cnt != CW'(DEPTH));
   assign out_valid = (b_reg.cnt != '0);
   assign out_data  = b_reg.mem[b_reg.rd];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Next state
   always_comb begin
      b_next = b_reg;
      if (push) begin
         b_next.mem[b_reg.wr] = in_data;
         b_next.wr            = sss_wrap(b_reg.wr);
      end
      if (pop) begin
         b_next.rd = sss_wrap(b_reg.rd);
      end
      if (push && !pop) begin
         b_next.cnt = b_reg.cnt + CW'(1);
      end else if (pop && !push) begin
         b_next.cnt = b_reg.cnt - CW'(1);
      end
   end

   // State register
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         b_reg <= '0;
      end else begin
         b_reg <= b_next;
      end
   end

   a_buf_bounded: assert property (@(posedge clk_sys) disable iff (rst)
      b_reg.cnt <= CW'(DEPTH))
      else $error("Buffer count above depth");

endmodule // sss_buf2

// [hw/sss_readout.sv]
`timescale 1ns/1ps
// ============================================================
// Spin sun sensor serial readout
module sss_readout import sss_pkg::*; #(
   parameter int unsigned BUF_DEPTH = SSS_BUF_DEPTH
) (
   // System clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 rst,
   // Readout link, redundant copies
   input  wire logic                 shift_clk_a,
   input  wire logic                 shift_clk_b,
   input  wire logic                 word_gate_a,
   input  wire logic                 word_gate_b,
   output logic                      serial_data_a,
   output logic                      serial_data_b,
   // Sensor head
   input  wire logic                 sun_pulse_in,
   input  wire logic [SSS_MAG_W-1:0] cell_array_a,
   input  wire logic [SSS_MAG_W-1:0] cell_array_b,
   input  wire logic                 quadrant_bit,
   // Telemetry sun pulse, redundant copies
   output logic                      sun_pulse_tm_a,
   output logic                      sun_pulse_tm_b,
   // Readout state
   output logic                      readout_inhibit
);

   // ============================================================
   // State types, one per clock domain
   typedef struct packed {
      logic                 sp_s1;
      logic                 sp_s2;
      logic                 sp_prev;
      logic [SSS_MAG_W-1:0] ca_s1;
      logic [SSS_MAG_W-1:0] ca_s2;
      logic [SSS_MAG_W-1:0] cb_s1;
      logic [SSS_MAG_W-1:0] cb_s2;
      logic                 qd_s1;
      logic                 qd_s2;
      logic                 wga_s1;
      logic                 wga_s2;
      logic                 wgb_s1;
      logic                 wgb_s2;
      logic                 busy_s1;
      logic                 busy_s2;
      logic                 busy_prev;
      logic                 inh;
      logic [SSS_REG_W-1:0] snap;
      logic                 tm_a;
      logic                 tm_b;
   } sss_sys_t;

   typedef struct packed {
      logic [SSS_REG_W-1:0] sr;
      logic [3:0]           cnt;
      logic                 busy;
      logic                 sda;
      logic                 sdb;
   } sss_link_t;

   sss_sys_t             s_reg;
   sss_sys_t             s_next;
   sss_link_t            l_reg;
   sss_link_t            l_next;

   logic                 link_clk;
   logic                 wg_link;
   logic                 sun_rise;
   logic                 inhibit;
   logic                 busy_fall;
   logic [SSS_REG_W-1:0] cap_word;
   logic                 cap_valid;
   logic                 cap_ready;
   logic                 upd_valid;
   logic                 upd_ready;
   logic [SSS_REG_W-1:0] upd_word;
   logic                 upd_fire;

   // ============================================================
   // Redundant link inputs
   // Either copy may carry the link; an idle copy must rest low,
   // as a copy stuck high would mask the other one.
   assign link_clk = shift_clk_a | shift_clk_b;
   assign wg_link  = word_gate_a | word_gate_b;

   // ============================================================
   // System domain: capture path
   // Pulse edge and photocell bits pass the same two stages, so
   // the sampled angle lines up with the detected edge.
   assign sun_rise  = s_reg.sp_s2 && !s_reg.sp_prev;
   assign busy_fall = !s_reg.busy_s2 && s_reg.busy_prev;

   // Update is blocked while either gate copy or the link is busy
   assign inhibit = s_reg.wga_s2 || s_reg.wgb_s2 || s_reg.busy_s2;

   // Capture word: sign, eight combined Gray bits, zero fill, flag
   always_comb begin
      cap_word                          = '0;
      cap_word[SSS_ANG_MSB]             = s_reg.qd_s2;
      cap_word[SSS_ANG_MSB-1:SSS_ANG_LSB] = s_reg.ca_s2 | s_reg.cb_s2;
      cap_word[SSS_STAT_POS]            = 1'b1;
   end

   // Pulses inside a readout are dropped, not queued
   assign cap_valid = sun_rise && !inhibit;
   // Drain only outside readouts so the snapshot stays still
   assign upd_ready = !inhibit;
   assign upd_fire  = upd_valid && upd_ready;

   // A pulse taken just before the gate arrives waits here
   sss_buf2 #(
      .WIDTH (SSS_REG_W),
      .DEPTH (BUF_DEPTH)
   ) u_buf (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .in_valid  (cap_valid),
      .in_ready  (cap_ready),
      .in_data   (cap_word),
      .out_valid (upd_valid),
      .out_ready (upd_ready),
      .out_data  (upd_word)
   );

   // ============================================================
   // System domain: next state
   always_comb begin
      s_next         = s_reg;
      // Two-stage synchronisers for every pin and the link level
      s_next.sp_s1   = sun_pulse_in;
      s_next.sp_s2   = s_reg.sp_s1;
      s_next.sp_prev = s_reg.sp_s2;
      s_next.ca_s1   = cell_array_a;
      s_next.ca_s2   = s_reg.ca_s1;
      s_next.cb_s1   = cell_array_b;
      s_next.cb_s2   = s_reg.cb_s1;
      s_next.qd_s1   = quadrant_bit;
      s_next.qd_s2   = s_reg.qd_s1;
      s_next.wga_s1  = word_gate_a;
      s_next.wga_s2  = s_reg.wga_s1;
      s_next.wgb_s1  = word_gate_b;
      s_next.wgb_s2  = s_reg.wgb_s1;
      s_next.busy_s1 = l_reg.busy;
      s_next.busy_s2 = s_reg.busy_s1;
      s_next.busy_prev = s_reg.busy_s2;
      s_next.inh     = inhibit;
      // Telemetry copies of the sun pulse, one flop each
      s_next.tm_a    = s_reg.sp_s2;
      s_next.tm_b    = s_reg.sp_s2;
      // Completed readout clears the flag
      if (busy_fall) begin
         s_next.snap[SSS_STAT_POS] = 1'b0;
      end
      // Placed last so a new capture wins over the clear
      if (upd_fire) begin
         s_next.snap = upd_word;
      end
   end

   // System domain register
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s_reg      <= '0;
         s_reg.snap <= SSS_SNAP_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   // ============================================================
   // Link domain: shifter
   // The snapshot is read across domains only while the gate has
   // frozen it; the gate must lead the first shift pulse by at
   // least three system cycles for that to hold.
   always_comb begin
      l_next = l_reg;
      if (!l_reg.busy) begin
         if (wg_link) begin
            // First pulse of a frame: load and present the sign bit
            l_next.busy = 1'b1;
            l_next.sr   = {s_reg.snap[SSS_REG_W-2:0], s_reg.snap[SSS_REG_W-1]};
            l_next.sda  = s_reg.snap[SSS_REG_W-1];
            l_next.sdb  = s_reg.snap[SSS_REG_W-1];
            l_next.cnt  = SSS_CNT_FIRST;
         end
      end else begin
         // Rotate so the content survives the readout
         l_next.sr  = {l_reg.sr[SSS_REG_W-2:0], l_reg.sr[SSS_REG_W-1]};
         l_next.sda = l_reg.sr[SSS_REG_W-1];
         l_next.sdb = l_reg.sr[SSS_REG_W-1];
         l_next.cnt = l_reg.cnt + 4'h1;
         if (l_reg.cnt == SSS_CNT_LAST) begin
            // Sixteenth pulse ends the second word
            l_next.busy = 1'b0;
            l_next.cnt  = SSS_CNT_RST;
         end
      end
   end

   // Link register; the shift clock may stop between frames, so
   // reset acts without it.
   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         l_reg     <= '0;
         l_reg.cnt <= SSS_CNT_RST;
      end else begin
         l_reg <= l_next;
      end
   end

   // ============================================================
   // Outputs
   assign serial_data_a   = l_reg.sda;
   assign serial_data_b   = l_reg.sdb;
   assign sun_pulse_tm_a  = s_reg.tm_a;
   assign sun_pulse_tm_b  = s_reg.tm_b;
   assign readout_inhibit = s_reg.inh;

   // ============================================================
   // Checks, system domain
   a_inhibit_freezes: assert property (
      @(posedge clk_sys) disable iff (rst)
      inhibit |=> $stable(s_reg.snap))
      else $error("Snapshot changed during readout inhibit");

   a_pulse_queued: assert property (
      @(posedge clk_sys) disable iff (rst)
      (sun_rise && !inhibit && cap_ready) |=> upd_valid)
      else $error("Sun pulse outside readout was not queued");

   a_capture_angle: assert property (
      @(posedge clk_sys) disable iff (rst)
      upd_fire |=> (s_reg.snap[SSS_ANG_MSB:SSS_ANG_LSB]
                    == $past(upd_word[SSS_ANG_MSB:SSS_ANG_LSB])))
      else $error("Angle bits not loaded on capture");

   a_status_sets: assert property (
      @(posedge clk_sys) disable iff (rst)
      upd_fire |=> s_reg.snap[SSS_STAT_POS])
      else $error("Status flag not set by capture");

   a_status_clears: assert property (
      @(posedge clk_sys) disable iff (rst)
      (busy_fall && !upd_fire) |=> !s_reg.snap[SSS_STAT_POS])
      else $error("Status flag not cleared after readout");

   a_tm_follows: assert property (
      @(posedge clk_sys) disable iff (rst)
      $rose(s_reg.sp_s2) |=> (sun_pulse_tm_a && sun_pulse_tm_b))
      else $error("Telemetry sun pulse copies missing");

   // ============================================================
   // Checks, link domain
   a_first_bit_sign: assert property (
      @(posedge link_clk) disable iff (rst)
      (!l_reg.busy && wg_link) |=> (l_reg.sda == $past(s_reg.snap[SSS_ANG_MSB])))
      else $error("First serial bit is not the sign bit");

   a_recirculate: assert property (
      @(posedge link_clk) disable iff (rst)
      (l_reg.busy && l_reg.cnt == SSS_CNT_LAST) |-> (l_next.sr == s_reg.snap))
      else $error("Register content lost after readout");

   a_data_copies: assert property (
      @(posedge link_clk) disable iff (rst)
      l_reg.busy |-> (serial_data_a == serial_data_b))
      else $error("Serial data copies differ");

   // Each rising shift edge inside a frame moves out the old top bit
   a_shift_order: assert property (
      @(posedge link_clk) disable iff (rst)
      l_reg.busy |=> (l_reg.sda == $past(l_reg.sr[SSS_REG_W-1])))
      else $error("Serial bit does not follow register order");

   // The sixteenth pulse must end the frame, or the next gate is ignored
   a_frame_end: assert property (
      @(posedge link_clk) disable iff (rst)
      (l_reg.busy && l_reg.cnt == SSS_CNT_LAST) |=> !l_reg.busy)
      else $error("Frame did not end after sixteen pulses");

   a_frame_count: assert property (
      @(posedge link_clk) disable iff (rst)
      l_reg.busy |-> (l_reg.cnt != SSS_CNT_RST))
      else $error("Pulse count zero inside a frame");

   a_idle_count: assert property (
      @(posedge link_clk) disable iff (rst)
      !l_reg.busy |-> (l_reg.cnt == SSS_CNT_RST))
      else $error("Pulse count not cleared between frames");

   a_gate_starts: assert property (
      @(posedge link_clk) disable iff (rst)
      (!l_reg.busy && wg_link) |=> l_reg.busy)
      else $error("Gated pulse did not start a frame");

   // ============================================================
   // Checks, system domain outputs and snapshot layout
   // The spare bits must stay zero; a reader may take the whole
   // second word as one value.
   a_fill_zero: assert property (
      @(posedge clk_sys) disable iff (rst)
      s_reg.snap[SSS_ANG_LSB-1:SSS_STAT_POS+1] == '0)
      else $error("Spare snapshot bits not zero");

   a_capture_sign: assert property (
      @(posedge clk_sys) disable iff (rst)
      upd_fire |=> (s_reg.snap[SSS_ANG_MSB] == $past(upd_word[SSS_ANG_MSB])))
      else $error("Sign bit not loaded on capture");

   // A capture in the cycle of the clear must leave the flag set
   a_set_wins: assert property (
      @(posedge clk_sys) disable iff (rst)
      (busy_fall && upd_fire) |=> s_reg.snap[SSS_STAT_POS])
      else $error("Clear won over a new capture");

   a_tm_copies: assert property (
      @(posedge clk_sys) disable iff (rst)
      sun_pulse_tm_a == sun_pulse_tm_b)
      else $error("Telemetry sun pulse copies differ");

   a_inhibit_out: assert property (
      @(posedge clk_sys) disable iff (rst)
      readout_inhibit == $past(inhibit))
      else $error("Inhibit output does not follow inhibit");

endmodule // sss_readout

// [testbench/sss_reader_model.sv]
`timescale 1ns/1ps
// ============================================================
// Telemetry reader: gated shift pulses, one copy of the link per frame
module sss_reader_model (
   // Bench control
   input  wire logic        go,
   input  wire logic        use_b,
   output logic             done,
   output logic [15:0]      word_a,
   output logic [15:0]      word_b,
   // Link to the device
   output logic             shift_clk_a,
   output logic             shift_clk_b,
   output logic             word_gate_a,
   output logic             word_gate_b,
   input  wire logic        serial_data_a,
   input  wire logic        serial_data_b
);
   // One frame per go; link clock stands low between frames
   initial begin
      {done, shift_clk_a, shift_clk_b, word_gate_a, word_gate_b} = 5'h00;
      {word_a, word_b} = 32'h0000_0000;
      forever begin
         @(posedge go);
         done = 1'b0;
         word_gate_a = !use_b;
         word_gate_b = use_b;
         #100; // Gate leads the first pulse by more than three system cycles
         for (int i = 0; i < 16; i++) begin
            shift_clk_a = !use_b;
            shift_clk_b = use_b;
            #40;
            // Sample on the falling edge, one bit per pulse, MSB first
            word_a = {word_a[14:0], serial_data_a};
            word_b = {word_b[14:0], serial_data_b};
            {shift_clk_a, shift_clk_b} = 2'b00;
            if (i == 7) begin
               {word_gate_a, word_gate_b} = 2'b00; // Gate over first word only
            end
            #40;
         end
         done = 1'b1;
      end
   end
endmodule // sss_reader_model

// [testbench/sss_readout_bench.sv]
`timescale 1ns/1ps
// ============================================================
// Bench for the spin sun sensor readout
module sss_readout_bench;
   import sss_pkg::*;
   logic        clk_sys, rst, go, use_b, done, sun_pulse_in, quadrant_bit;
   logic        shift_clk_a, shift_clk_b, word_gate_a, word_gate_b;
   logic        serial_data_a, serial_data_b, sun_pulse_tm_a, sun_pulse_tm_b;
   logic        readout_inhibit;
   logic [7:0]  cell_array_a, cell_array_b;
   logic [15:0] word_a, word_b, expv;
   logic [16:0] rows [4];
   int          mismatches, total_checks, cyc;

   sss_readout dut (.clk_sys(clk_sys), .rst(rst), .shift_clk_a(shift_clk_a),
      .shift_clk_b(shift_clk_b), .word_gate_a(word_gate_a), .word_gate_b(word_gate_b),
      .serial_data_a(serial_data_a), .serial_data_b(serial_data_b),
      .sun_pulse_in(sun_pulse_in), .cell_array_a(cell_array_a),
      .cell_array_b(cell_array_b), .quadrant_bit(quadrant_bit),
      .sun_pulse_tm_a(sun_pulse_tm_a), .sun_pulse_tm_b(sun_pulse_tm_b),
      .readout_inhibit(readout_inhibit));
   sss_reader_model reader (.go(go), .use_b(use_b), .done(done), .word_a(word_a),
      .word_b(word_b), .shift_clk_a(shift_clk_a), .shift_clk_b(shift_clk_b),
      .word_gate_a(word_gate_a), .word_gate_b(word_gate_b),
      .serial_data_a(serial_data_a), .serial_data_b(serial_data_b));

   // ============================================================
   // Clock and hang guard; a frame takes under 60 system cycles
   initial clk_sys = 1'b0;
   always #12.5 clk_sys = !clk_sys;
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 5000) begin
         mismatches++;
         test_done();
      end
   end

   // ============================================================
   // Shared tasks
   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (e !== g) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask

   // Head pulse with new cell data; pins change just after an edge
   task automatic sun(input logic [16:0] r);
      @(posedge clk_sys);
      #1 {quadrant_bit, cell_array_a, cell_array_b} = r;
      @(posedge clk_sys);
      #1 sun_pulse_in = 1'b1;
      repeat (4) @(posedge clk_sys);
      #1 chk("tm pulse", 16'h0003, {14'h0, sun_pulse_tm_a, sun_pulse_tm_b});
      sun_pulse_in = 1'b0;
      repeat (8) @(posedge clk_sys);
   endtask

   // One readout; optionally fire a pulse in mid-frame
   task automatic frame(input logic b, input logic hit, input logic [16:0] r);
      @(posedge clk_sys);
      #1 use_b = b;
      go = 1'b1;
      @(posedge clk_sys);
      #1 go = 1'b0;
      for (int n = 0; n < 100 && done !== 1'b1; n++) begin
         if (hit && n == 20) begin
            chk("inhibit", 16'h0001, {15'h0, readout_inhibit});
            sun(r);
         end
         @(posedge clk_sys);
      end
      repeat (10) @(posedge clk_sys);
      #1 chk("inhibit end", 16'h0000, {15'h0, readout_inhibit});
      chk("copies", b ? word_b : word_a, b ? word_a : word_b);
   endtask

   // Reader side Gray to binary conversion of the eight angle bits
   function automatic logic [7:0] g2b(input logic [7:0] g);
      logic [7:0] b;
      b[7] = g[7];
      for (int k = 6; k >= 0; k--) b[k] = b[k+1] ^ g[k];
      return b;
   endfunction

   // ============================================================
   // Verdict
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ============================================================
   // Rows: {sign, array a, array b}; word is {sign, a|b, zeros, status}
   initial begin
      rows = '{17'h1_0a_50, 17'h0_ff_00, 17'h1_81_18, 17'h0_00_01};
      {go, use_b, sun_pulse_in, quadrant_bit} = 4'h0;
      {cell_array_a, cell_array_b} = 16'h0000;
      {mismatches, total_checks, cyc} = '0;
      rst = 1'b1;
      repeat (8) @(posedge clk_sys);
      #1 chk("reset outs", 16'h0000, {13'h0, serial_data_a, sun_pulse_tm_a, readout_inhibit});
      rst = 1'b0;
      repeat (4) @(posedge clk_sys);
      foreach (rows[i]) begin
         expv = {rows[i][16], rows[i][15:8] | rows[i][7:0], 6'h00, 1'b1};
         sun(rows[i]);
         frame(i[0], 1'b0, rows[i]);
         chk("word", expv, i[0] ? word_b : word_a);
         if (i == 0) chk("angle n", 16'h006c, {8'h00, g2b(word_a[14:7])});
      end
      // Repeat read without a pulse: same angle, status cleared
      frame(1'b0, 1'b0, rows[0]);
      chk("reread", {expv[15:1], 1'b0}, word_a);
      // Pulse inside a readout is dropped
      frame(1'b0, 1'b1, rows[1]);
      frame(1'b1, 1'b0, rows[0]);
      chk("dropped", {expv[15:1], 1'b0}, word_b);
      // Capture works again once the readout is over
      sun(rows[2]);
      frame(1'b0, 1'b0, rows[0]);
      chk("after", 16'hcc81, word_a);
      test_done();
   end
endmodule // sss_readout_bench
